/* src/mas_regs.svh */
// Purpose: register offsets, fields and reset values of the status bank
// Assumes: printed offsets are word indices; byte address is index * 4
// Notes: constants only, no logic
`ifndef MAS_REGS_SVH
`define MAS_REGS_SVH

// ----------------------------------------------------------------
// Word indices
// ----------------------------------------------------------------
`define MAS_IDX_STATE 11'h18E
`define MAS_IDX_SPEED 11'h194
`define MAS_IDX_BETA_AXIS_VOLTAGE 11'h400
`define MAS_IDX_SUPPLY 11'h40C
`define MAS_IDX_WIND1 11'h444
`define MAS_IDX_WIND2 11'h446
`define MAS_IDX_CTRL 11'h700
`define MAS_IDX_BASE 11'h701
`define MAS_IDX_STATUS 11'h702
`define MAS_IDX_MASK 11'h703
`define MAS_IDX_COUNT 11'h704

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define MAS_CTRL_FREEZE 0
`define MAS_EV_CHANGE 0
`define MAS_EV_FAULT 1
`define MAS_EV_MDONE 2
`define MAS_EV_MFAULT 3
`define MAS_EV_SAMPLE 4
`define MAS_EV_NUM 5
`define MAS_STATE_RESET 16'h0000
`define MAS_WORD_RESET 32'h00000000
`define MAS_BASE_RESET 32'h00000000
`define MAS_MASK_RESET 5'h00
`define MAS_STATE_LAST 5'h18

`endif

/* src/mas_pkg.sv */
// Purpose: shared types of the status bank
// Assumes: offsets and fields come from mas_regs.svh
// Notes: no logic here
package mas_pkg;

	// ------------------------------------------------------------
	// Control state codes
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		MAS_IDLE = 5'h00,
		MAS_SPIN_DETECT = 5'h01,
		MAS_TRISTATE = 5'h02,
		MAS_BRAKE_START = 5'h03,
		MAS_POS_DETECT = 5'h04,
		MAS_SLOW_FIRST = 5'h05,
		MAS_ALIGN = 5'h06,
		MAS_OPEN_LOOP = 5'h07,
		MAS_CL_UNALIGNED = 5'h08,
		MAS_CL_ALIGNED = 5'h09,
		MAS_CL_BRAKING = 5'h0A,
		MAS_SOFT_STOP = 5'h0B,
		MAS_RECIRC_STOP = 5'h0C,
		MAS_BRAKE_STOP = 5'h0D,
		MAS_FAULT = 5'h0E,
		MAS_PM_STOP_CHECK = 5'h0F,
		MAS_PM_STOP_WAIT = 5'h10,
		MAS_PM_BRAKE = 5'h11,
		MAS_PM_INIT = 5'h12,
		MAS_PM_RL = 5'h13,
		MAS_PM_BEMF = 5'h14,
		MAS_PM_STALL = 5'h15,
		MAS_PM_TORQUE = 5'h16,
		MAS_PM_DONE = 5'h17,
		MAS_PM_FAULT = 5'h18
	} mas_state_type;

	// ------------------------------------------------------------
	// Telemetry set, produced in one algorithm cycle
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] speed;
		logic [31:0] beta_axis_voltage;
		logic [31:0] supply;
		logic [31:0] wind1;
		logic [31:0] wind2;
	} mas_telemetry_type;

	typedef struct packed {
		logic [12:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} mas_avl_req_type;

endpackage : mas_pkg

/* src/mas_state_track.sv */
// Purpose: holds the current control state and flags state events
// Assumes: algorithm presents a code with a one-cycle valid strobe
// Notes: codes above the last legal one are dropped
`timescale 1ns/1ps
`include "mas_regs.svh"
module mas_state_track (
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] algState,
	input wire logic algStateValid,
	output mas_pkg::mas_state_type state,
	output logic [`MAS_EV_NUM-1:0] stateEvents
);

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	logic legal;
	assign legal = algStateValid && (algState <= `MAS_STATE_LAST);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= mas_pkg::MAS_IDLE;
		end else if (legal) begin
			state <= mas_pkg::mas_state_type'(algState);
		end
	end

	// ------------------------------------------------------------
	// Events, one-cycle pulses on entry only
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stateEvents <= '0;
		end else begin
			stateEvents <= '0;
			if (legal && algState != state) begin
				stateEvents[`MAS_EV_CHANGE] <= 1'b1;
				stateEvents[`MAS_EV_FAULT] <= algState == mas_pkg::MAS_FAULT;
				stateEvents[`MAS_EV_MDONE] <= algState == mas_pkg::MAS_PM_DONE;
				stateEvents[`MAS_EV_MFAULT] <= algState == mas_pkg::MAS_PM_FAULT;
			end
		end
	end

endmodule : mas_state_track

/* src/mas_irq.sv */
// Purpose: sticky event status, mask and level interrupt
// Assumes: clear is a write-one-to-clear pulse vector
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
`include "mas_regs.svh"
module mas_irq (
	input wire logic clk,
	input wire logic rst,
	input wire logic [`MAS_EV_NUM-1:0] events,
	input wire logic [`MAS_EV_NUM-1:0] clear,
	input wire logic [`MAS_EV_NUM-1:0] mask,
	output logic [`MAS_EV_NUM-1:0] status,
	output logic irq
);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status <= '0;
		end else begin
			status <= (status & ~clear) | events;
		end
	end

	// Registered, so it follows status by one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

endmodule : mas_irq

/* src/mas_bank.sv */
// Purpose: motor algorithm status and telemetry bank; state and telemetry words are read-only
// Assumes: Avalon-MM slave, byte addresses, 32-bit words
// Notes: every access is answered with one wait cycle
`timescale 1ns/1ps
`include "mas_regs.svh"
module mas_bank (
	input wire logic clk,
	input wire logic rst,
	input wire mas_pkg::mas_avl_req_type avlReq,
	output logic [31:0] avlReaddata,
	output logic avlWaitrequest,
	input wire logic [4:0] algState,
	input wire logic algStateValid,
	input wire mas_pkg::mas_telemetry_type telemetry,
	input wire logic telemetryValid,
	output mas_pkg::mas_telemetry_type telemetrySnapshot,
	output logic [15:0] controlStateCode,
	output logic [31:0] speedBaseHz,
	output logic irq
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic [10:0] index;
	logic aligned;
	logic request;
	logic firstCycle;
	logic doWrite;
	logic doRead;
	logic [31:0] byteMask;

	assign index = avlReq.address[12:2];
	assign aligned = avlReq.address[1:0] == 2'h0;
	assign request = avlReq.read || avlReq.write;
	assign firstCycle = request && avlWaitrequest;
	// Write lands on the edge where waitrequest is seen low
	assign doWrite = avlReq.write && !avlWaitrequest && aligned;
	assign doRead = avlReq.read && avlWaitrequest;

	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : gLane
			assign byteMask[lane*8 +: 8] = {8{avlReq.byteenable[lane]}};
		end
	endgenerate

	// ------------------------------------------------------------
	// Wait state
	// ------------------------------------------------------------
	// One fixed wait cycle keeps read data registered and the
	// answer time the same for every address
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avlWaitrequest <= 1'b1;
		end else if (firstCycle) begin
			avlWaitrequest <= 1'b0;
		end else begin
			avlWaitrequest <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Control state tracking
	// ------------------------------------------------------------
	mas_pkg::mas_state_type state;
	logic [`MAS_EV_NUM-1:0] stateEvents;

	mas_state_track uTrack (
		.clk(clk),
		.rst(rst),
		.algState(algState),
		.algStateValid(algStateValid),
		.state(state),
		.stateEvents(stateEvents)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			controlStateCode <= `MAS_STATE_RESET;
		end else begin
			controlStateCode <= {11'h000, state};
		end
	end

	// ------------------------------------------------------------
	// Control and speed base
	// ------------------------------------------------------------
	logic freeze;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			freeze <= 1'b0;
		end else if (doWrite && index == `MAS_IDX_CTRL &&
				avlReq.byteenable[0]) begin
			freeze <= avlReq.writedata[`MAS_CTRL_FREEZE];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			speedBaseHz <= `MAS_BASE_RESET;
		end else if (doWrite && index == `MAS_IDX_BASE) begin
			speedBaseHz <= (speedBaseHz & ~byteMask) |
				(avlReq.writedata & byteMask);
		end
	end

	// ------------------------------------------------------------
	// Telemetry snapshot
	// ------------------------------------------------------------
	// All five words load on one edge, so a set never mixes
	// two algorithm cycles; freeze holds the set for software
	logic takeSample;
	logic [15:0] sampleCount;

	assign takeSample = telemetryValid && !freeze;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			telemetrySnapshot <= '0;
		end else if (takeSample) begin
			telemetrySnapshot <= telemetry;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sampleCount <= 16'h0000;
		end else if (takeSample) begin
			sampleCount <= sampleCount + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------
	logic [`MAS_EV_NUM-1:0] events;
	logic [`MAS_EV_NUM-1:0] clear;
	logic [`MAS_EV_NUM-1:0] status;
	logic [`MAS_EV_NUM-1:0] mask;

	always_comb begin
		events = stateEvents;
		events[`MAS_EV_SAMPLE] = takeSample;
	end

	assign clear = (doWrite && index == `MAS_IDX_STATUS &&
		avlReq.byteenable[0]) ? avlReq.writedata[`MAS_EV_NUM-1:0] : '0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mask <= `MAS_MASK_RESET;
		end else if (doWrite && index == `MAS_IDX_MASK &&
				avlReq.byteenable[0]) begin
			mask <= avlReq.writedata[`MAS_EV_NUM-1:0];
		end
	end

	mas_irq uIrq (
		.clk(clk),
		.rst(rst),
		.events(events),
		.clear(clear),
		.mask(mask),
		.status(status),
		.irq(irq)
	);

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	logic [31:0] next_readdata;

	always_comb begin
		next_readdata = 32'h00000000;
		if (aligned) begin
			unique case (index)
				`MAS_IDX_STATE: begin
					next_readdata = {16'h0000, controlStateCode};
				end
				`MAS_IDX_SPEED: begin
					next_readdata = telemetrySnapshot.speed;
				end
				`MAS_IDX_BETA_AXIS_VOLTAGE: begin
					next_readdata = telemetrySnapshot.beta_axis_voltage;
				end
				`MAS_IDX_SUPPLY: begin
					next_readdata = telemetrySnapshot.supply;
				end
				`MAS_IDX_WIND1: begin
					next_readdata = telemetrySnapshot.wind1;
				end
				`MAS_IDX_WIND2: begin
					next_readdata = telemetrySnapshot.wind2;
				end
				`MAS_IDX_CTRL: begin
					next_readdata = {31'h00000000, freeze};
				end
				`MAS_IDX_BASE: begin
					next_readdata = speedBaseHz;
				end
				`MAS_IDX_STATUS: begin
					next_readdata = {27'h0000000, status};
				end
				`MAS_IDX_MASK: begin
					next_readdata = {27'h0000000, mask};
				end
				`MAS_IDX_COUNT: begin
					next_readdata = {16'h0000, sampleCount};
				end
				default: begin
					next_readdata = 32'h00000000;
				end
			endcase
		end
	end

	// Data loads in the wait cycle and stands at the answer edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avlReaddata <= `MAS_WORD_RESET;
		end else if (doRead) begin
			avlReaddata <= next_readdata;
		end
	end

endmodule : mas_bank

/* bench/mas_bank_checker.sv */
// Purpose: port relations of the status bank
// Assumes: one clock domain, reset asynchronous and active high
// Notes: bound to mas_bank below
`timescale 1ns/1ps
`include "mas_regs.svh"
module mas_bank_checker (
	input wire logic clk,
	input wire logic rst,
	input wire mas_pkg::mas_avl_req_type avlReq,
	input wire logic [31:0] avlReaddata,
	input wire logic avlWaitrequest,
	input wire logic [4:0] algState,
	input wire logic algStateValid,
	input wire mas_pkg::mas_telemetry_type telemetry,
	input wire logic telemetryValid,
	input wire mas_pkg::mas_telemetry_type telemetrySnapshot,
	input wire logic [15:0] controlStateCode
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Answer cycle of a read to word index i
	sequence s_rd(logic [10:0] i);
		avlReq.read && !avlWaitrequest && avlReq.address == {i, 2'b00};
	endsequence
	sequence s_good;
		algStateValid && algState <= 5'h18;
	endsequence
	sequence s_bad;
		algStateValid && algState > 5'h18 ##1 !algStateValid;
	endsequence
	property p_range;
		controlStateCode <= 16'h0018;
	endproperty
	a_range: assert property (p_range) else $error("code range");
	property p_load;
		s_good |-> ##2 controlStateCode == {11'h000, $past(algState, 2)};
	endproperty
	a_load: assert property (p_load) else $error("code load");
	property p_bad;
		s_bad |-> ##1 $stable(controlStateCode);
	endproperty
	a_bad: assert property (p_bad) else $error("bad code taken");
	property p_snap;
		!$stable(telemetrySnapshot) |->
			$past(telemetryValid) && telemetrySnapshot == $past(telemetry);
	endproperty
	a_snap: assert property (p_snap) else $error("torn set");
	property p_st;
		s_rd(`MAS_IDX_STATE) |->
			avlReaddata == {16'h0000, $past(controlStateCode)};
	endproperty
	a_st: assert property (p_st) else $error("state read");
	property p_spd;
		s_rd(`MAS_IDX_SPEED) |->
			avlReaddata == $past(telemetrySnapshot.speed);
	endproperty
	a_spd: assert property (p_spd) else $error("speed read");
	property p_beta;
		s_rd(11'h400) |-> avlReaddata == $past(telemetrySnapshot[127:96]);
	endproperty
	a_beta: assert property (p_beta) else $error("beta read");
	property p_sup;
		s_rd(`MAS_IDX_SUPPLY) |->
			avlReaddata == $past(telemetrySnapshot.supply);
	endproperty
	a_sup: assert property (p_sup) else $error("supply read");
	property p_w1;
		s_rd(`MAS_IDX_WIND1) |-> avlReaddata == $past(telemetrySnapshot.wind1);
	endproperty
	a_w1: assert property (p_w1) else $error("wind1 read");
	property p_w2;
		s_rd(`MAS_IDX_WIND2) |-> avlReaddata == $past(telemetrySnapshot.wind2);
	endproperty
	a_w2: assert property (p_w2) else $error("wind2 read");
endmodule : mas_bank_checker

bind mas_bank mas_bank_checker chk (.clk, .rst, .avlReq, .avlReaddata,
	.avlWaitrequest, .algState, .algStateValid, .telemetry,
	.telemetryValid, .telemetrySnapshot, .controlStateCode);

/* bench/mas_bank_bench.sv */
// Purpose: self-checking bench of the status bank
// Assumes: slave answers in its own time; only the watchdog ends a wait
// Notes: all bus traffic goes through task bus
`timescale 1ns/1ps
`include "mas_regs.svh"
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) fail(n, e, g); end
module mas_bank_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	mas_pkg::mas_avl_req_type req = '0;
	logic [31:0] rdata;
	logic waitReq;
	logic [4:0] algState = 5'h00;
	logic algStateValid = 1'b0;
	mas_pkg::mas_telemetry_type tel = '0;
	logic telValid = 1'b0;
	mas_pkg::mas_telemetry_type snap;
	logic [15:0] code;
	logic [31:0] baseHz;
	logic irq;
	logic [31:0] q;
	logic [31:0] w [5] = '{32'hFFFFFFFF, 32'h80000000, 32'h08000000,
		32'hF8000000, 32'h00000001};
	logic [10:0] ix [6] = '{`MAS_IDX_SPEED, 11'h400, `MAS_IDX_SUPPLY,
		`MAS_IDX_WIND1, `MAS_IDX_WIND2, `MAS_IDX_STATE};
	int nErrors = 0;
	int checkCount = 0;
	int cycles = 0;
	mas_bank uut (.clk(clk), .rst(rst), .avlReq(req), .avlReaddata(rdata),
		.avlWaitrequest(waitReq), .algState(algState),
		.algStateValid(algStateValid), .telemetry(tel),
		.telemetryValid(telValid), .telemetrySnapshot(snap),
		.controlStateCode(code), .speedBaseHz(baseHz), .irq(irq));
	// ------------------------------------------------------------
	// Clock, watchdog and shared tasks
	// ------------------------------------------------------------
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			nErrors++;
			test_done();
		end
	end
	task fail(input string n, input logic [159:0] e, input logic [159:0] g);
		$display("[FAIL] %s expected %h seen %h", n, e, g);
		nErrors++;
	endtask : fail
	task test_done;
		$display("checks %0d errors %0d", checkCount, nErrors);
		if (nErrors == 0 && checkCount > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : test_done
	// Holds the request until waitrequest is seen low at an edge
	task bus(input logic wr, input logic [10:0] i, input logic [31:0] d);
		req <= '{address: {i, 2'b00}, read: !wr, write: wr, writedata: d,
			byteenable: 4'hF};
		@(posedge clk);
		while (waitReq !== 1'b0) begin
			@(posedge clk);
		end
		q = rdata;
		req <= '0;
		@(posedge clk);
	endtask : bus
	task load(input logic [159:0] v);
		tel <= v;
		telValid <= 1'b1;
		@(posedge clk);
		telValid <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : load
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_reset;
		for (int k = 0; k < 6; k++) begin
			bus(1'b0, ix[k], 32'h0);
			`CHK("reset word", 32'h0, q)
		end
	endtask : t_reset
	task t_codes;
		for (int c = 0; c < 26; c++) begin
			algState <= c[4:0];
			algStateValid <= 1'b1;
			@(posedge clk);
			algStateValid <= 1'b0;
			repeat (2) @(posedge clk);
			bus(1'b0, `MAS_IDX_STATE, 32'h0);
			// Code 19h must leave 18h in place
			`CHK("state", (c > 24) ? 32'h18 : c, q)
		end
		bus(1'b1, `MAS_IDX_STATE, 32'h3);
		bus(1'b0, `MAS_IDX_STATE, 32'h0);
		`CHK("state ro", 32'h18, q)
		// Change, fault, measurement done and measurement fault seen
		bus(1'b0, `MAS_IDX_STATUS, 32'h0);
		`CHK("state events", 32'h0F, q)
	endtask : t_codes
	task t_telem;
		// Back to back sets: only the second may be seen
		tel <= ~{w[0], w[1], w[2], w[3], w[4]};
		telValid <= 1'b1;
		@(posedge clk);
		load({w[0], w[1], w[2], w[3], w[4]});
		`CHK("snapshot", {w[0], w[1], w[2], w[3], w[4]}, snap)
		for (int k = 0; k < 5; k++) begin
			bus(1'b0, ix[k], 32'h0);
			`CHK("telemetry", w[k], q)
		end
	endtask : t_telem
	task t_irq;
		bus(1'b1, `MAS_IDX_STATUS, 32'h1F);
		bus(1'b1, `MAS_IDX_MASK, 32'h10);
		load('0);
		`CHK("irq set", 1'b1, irq)
		bus(1'b0, `MAS_IDX_STATUS, 32'h0);
		`CHK("status", 32'h10, q)
		bus(1'b1, `MAS_IDX_STATUS, 32'h10);
		// Irq is registered, one cycle behind the cleared status
		@(posedge clk);
		`CHK("irq clear", 1'b0, irq)
		bus(1'b1, `MAS_IDX_MASK, 32'h0);
		load('0);
		`CHK("irq masked", 1'b0, irq)
	endtask : t_irq
	task t_base;
		bus(1'b1, `MAS_IDX_BASE, 32'h000001F4);
		bus(1'b0, `MAS_IDX_BASE, 32'h0);
		`CHK("base read", 32'h000001F4, q)
		`CHK("base port", 32'h000001F4, baseHz)
		bus(1'b1, 11'h7FF, 32'hFFFFFFFF);
		bus(1'b0, 11'h7FF, 32'h0);
		`CHK("unmapped", 32'h0, q)
		bus(1'b1, `MAS_IDX_CTRL, 32'h1);
		bus(1'b0, `MAS_IDX_CTRL, 32'h0);
		`CHK("freeze bit", 32'h1, q)
		load({5{32'h12345678}});
		bus(1'b0, `MAS_IDX_SPEED, 32'h0);
		`CHK("frozen", 32'h0, q)
		// Two sets in t_telem, two in t_irq; the frozen one not counted
		bus(1'b0, `MAS_IDX_COUNT, 32'h0);
		`CHK("sample count", 32'h4, q)
		bus(1'b1, `MAS_IDX_CTRL, 32'h0);
	endtask : t_base
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_codes();
		t_telem();
		t_irq();
		t_base();
		test_done();
	end
endmodule : mas_bank_bench
